/* rtl/uisd_pkg.sv */
// Constants and types for the host command decoder.
package uisd_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_SERVICE = 8'h06;
  localparam logic [7:0] CMD_INFO    = 8'h07;
  localparam logic [7:0] CMD_GET     = 8'h08;
  localparam logic [7:0] CMD_PROPS   = 8'h09;
  localparam logic [7:0] CMD_SET     = 8'h0A;

  // ==========================================================
  // Service properties
  localparam logic [7:0] SVC_START  = 8'h01;
  localparam logic [7:0] SVC_FINISH = 8'h02;
  localparam logic [7:0] SVC_DIALOG = 8'h03;
  localparam logic [7:0] SVC_DROP   = 8'h04;
  localparam logic [7:0] SVC_INIT   = 8'h09;

  // ==========================================================
  // Info selectors
  localparam logic [7:0] INFO_GENERAL = 8'h01;
  localparam logic [7:0] INFO_DIALOG  = 8'h02;
  localparam logic [7:0] INFO_CONTROL = 8'h03;

  // ==========================================================
  // Property flags and sizes
  localparam logic [7:0]  FLAG_HIDE   = 8'h01;
  localparam logic [7:0]  FLAG_SCROLL = 8'h10;
  localparam logic [7:0]  FLAG_COLOUR = 8'h40;
  localparam logic [7:0]  PROPS_LEN   = 8'd12;
  localparam logic [7:0]  MIN_LEN     = 8'd2;
  localparam logic [15:0] SEG_BYTES   = 16'h0010;

  // ==========================================================
  // Byte positions within a frame, length byte at zero
  localparam logic [7:0] BUF_BYTES = 8'd12;
  localparam logic [3:0] POS_CODE  = 4'h1;
  localparam logic [3:0] POS_ARG   = 4'h2;
  localparam logic [3:0] POS_ID_HI = 4'h2;
  localparam logic [3:0] POS_ID_LO = 4'h3;
  localparam logic [3:0] POS_Q_HI  = 4'h3;
  localparam logic [3:0] POS_Q_LO  = 4'h4;
  localparam logic [3:0] POS_OFF_L = 4'h4;
  localparam logic [3:0] POS_OFF_H = 4'h5;
  localparam logic [3:0] POS_PROP  = 4'h4;
  localparam logic [3:0] POS_ICON  = 4'h6;
  localparam logic [3:0] POS_RED   = 4'h8;
  localparam logic [3:0] POS_GRN   = 4'h9;
  localparam logic [3:0] POS_BLU   = 4'hA;
  localparam logic [7:0] POS_DATA  = 8'd6;

  // ==========================================================
  // Decoder states
  typedef enum logic [2:0] {
    ST_LEN  = 3'b000,
    ST_BODY = 3'b001,
    ST_EXEC = 3'b010,
    ST_READ = 3'b011,
    ST_INFO = 3'b100
  } uisd_state_e;

endpackage : uisd_pkg

/* rtl/uisd_decoder.sv */
// Host command decoder for the user-interface server.
`timescale 1ns/1ps

// Contract
// RULE1 - dialog select carries one index byte
// RULE2 - dialog index zero selects first dialog
// RULE3 - disconnect drops client, service keeps running
// RULE4 - start and init-data restore control data
// RULE5 - code 0x07 is an info query
// RULE6 - selectors general, dialog index, control id
// RULE7 - one info answer, two for control
// RULE8 - queries are not checked for sense
// RULE9 - control id follows the command code
// RULE10 - code 0x08 reads control, service optional
// RULE11 - read answers per 16-byte segment
// RULE12 - properties forwarded to client, not stored
// RULE13 - properties frame totals twelve bytes
// RULE14 - flags ORed, hide, icon, buttons nibbles
// RULE15 - message shown only with its dialog
// RULE16 - scroll flag 0x10, colour valid 0x40
// RULE17 - colour bytes red, green, blue, zero
// RULE18 - code 0x0A writes control, service optional
// RULE19 - little-endian offset precedes write data
// RULE20 - zero offset segment completes the update
// RULE21 - latch, password, section hold one byte
// RULE22 - list and number hold four bytes
// RULE23 - date-time eight bytes, some controls none
// RULE24 - frame opens with its total length
// RULE25 - unknown frames discarded, alignment kept
module uisd_decoder (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Host byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_ready,
  // Programmed interface lookup
  output logic [15:0]      lookup_id,
  input  wire logic [15:0] ctl_size,
  input  wire logic [7:0]  ctl_dialog,
  input  wire logic        client_connected,
  // Service control
  output logic             service_running,
  output logic [7:0]       dialog_index,
  output logic             dialog_select,
  output logic             client_drop,
  output logic             data_init,
  // Info queries
  output logic             info_valid,
  output logic [7:0]       info_sel,
  output logic [15:0]      info_arg,
  output logic             info_part,
  // Control reads
  output logic             rd_valid,
  output logic [15:0]      rd_id,
  output logic [15:0]      rd_offset,
  // Properties to the client
  output logic             props_valid,
  output logic [15:0]      props_id,
  output logic [31:0]      props_bytes,
  output logic [7:0]       colour_red,
  output logic [7:0]       colour_green,
  output logic [7:0]       colour_blue,
  output logic             scroll_req,
  output logic             colour_apply,
  output logic             msg_hide,
  output logic [3:0]       msg_icon,
  output logic [3:0]       msg_buttons,
  output logic             msg_show,
  // Control writes
  output logic             wr_valid,
  output logic [15:0]      wr_id,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic             wr_done,
  // Discarded frames
  output logic             frame_drop
);

  // ==========================================================
  // State
  typedef struct packed {
    uisd_pkg::uisd_state_e st;
    logic [7:0]            len;
    logic [7:0]            cnt;
    logic [11:0][7:0]      b;
    logic                  run;
    logic [7:0]            dlg;
    logic                  dlg_sel;
    logic                  drop;
    logic                  init;
    logic                  iv;
    logic [7:0]            isel;
    logic [15:0]           iarg;
    logic                  ipart;
    logic                  rv;
    logic [15:0]           rid;
    logic [15:0]           roff;
    logic                  pv;
    logic [15:0]           pid;
    logic [31:0]           pbytes;
    logic [7:0]            red;
    logic [7:0]            grn;
    logic [7:0]            blu;
    logic                  scroll;
    logic                  capply;
    logic                  hide;
    logic [3:0]            icon;
    logic [3:0]            btns;
    logic                  show;
    logic                  wv;
    logic [15:0]           wid;
    logic [15:0]           waddr;
    logic [7:0]            wdata;
    logic                  wdone;
    logic                  fdrop;
  } uisd_state_s;

  uisd_state_s s;
  uisd_state_s next_s;

  logic [7:0]  code;
  logic [15:0] frame_id;
  logic [15:0] next_roff;

  assign code      = s.b[uisd_pkg::POS_CODE];
  assign frame_id  = {s.b[uisd_pkg::POS_ID_HI], s.b[uisd_pkg::POS_ID_LO]};
  assign next_roff = s.roff + uisd_pkg::SEG_BYTES;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s         = s;
    next_s.dlg_sel = 1'b0;
    next_s.drop    = 1'b0;
    next_s.init    = 1'b0;
    next_s.iv      = 1'b0;
    next_s.rv      = 1'b0;
    next_s.pv      = 1'b0;
    next_s.wv      = 1'b0;
    next_s.wdone   = 1'b0;
    next_s.fdrop   = 1'b0;
    case (s.st)
      uisd_pkg::ST_LEN:
      begin
        if (rx_valid)
        begin
          next_s.len = rx_byte; // see RULE24
          next_s.cnt = 8'h01;
          next_s.b   = '0;
          // A frame too short for a code is consumed whole.
          if (rx_byte < uisd_pkg::MIN_LEN)
            next_s.fdrop = 1'b1;
          else
            next_s.st = uisd_pkg::ST_BODY;
        end
      end
      uisd_pkg::ST_BODY:
      begin
        // The address steps once after each byte handed out but the frame's last, so a gap in
        // the byte stream leaves it on the next free place.
        if (s.wv)
          next_s.waddr = s.waddr + 16'h0001;
        if (rx_valid)
        begin
          if (s.cnt < uisd_pkg::BUF_BYTES)
            next_s.b[s.cnt[3:0]] = rx_byte;
          next_s.cnt = s.cnt + 8'h01;
          if (s.cnt == {4'h0, uisd_pkg::POS_OFF_H})
            next_s.waddr = {rx_byte, s.b[uisd_pkg::POS_OFF_L]}; // see RULE19
          // Data bytes go out in frame order, so little-endian fields of
          // any control type land at rising addresses untouched.
          if (code == uisd_pkg::CMD_SET && s.cnt >= uisd_pkg::POS_DATA)
          begin
            next_s.wv    = 1'b1; // see RULE18 see RULE21 see RULE22
            next_s.wid   = frame_id; // see RULE9 see RULE23
            next_s.wdata = rx_byte;
          end
          if (s.cnt == s.len - 8'h01)
            next_s.st = uisd_pkg::ST_EXEC; // see RULE25
        end
      end
      uisd_pkg::ST_EXEC:
      begin
        next_s.st = uisd_pkg::ST_LEN;
        case (code)
          uisd_pkg::CMD_SERVICE:
          begin
            case (s.b[uisd_pkg::POS_ARG])
              uisd_pkg::SVC_START:
              begin
                next_s.run  = 1'b1;
                next_s.init = 1'b1; // see RULE4
              end
              uisd_pkg::SVC_FINISH: next_s.run = 1'b0;
              uisd_pkg::SVC_DIALOG:
              begin
                next_s.dlg     = s.b[uisd_pkg::POS_Q_HI]; // see RULE1
                next_s.dlg_sel = 1'b1; // see RULE2
              end
              uisd_pkg::SVC_DROP: next_s.drop = 1'b1; // see RULE3
              uisd_pkg::SVC_INIT: next_s.init = 1'b1; // see RULE4
              default:            next_s.fdrop = 1'b1; // see RULE25
            endcase
          end
          uisd_pkg::CMD_INFO:
          begin
            // Arguments are passed on unchecked; the answer source may
            // reply with nonsense to a nonsense query.
            next_s.isel  = s.b[uisd_pkg::POS_ARG]; // see RULE5 see RULE8
            next_s.ipart = 1'b0;
            next_s.iv    = 1'b1;
            case (s.b[uisd_pkg::POS_ARG])
              uisd_pkg::INFO_GENERAL: next_s.iarg = 16'h0000; // see RULE6
              uisd_pkg::INFO_DIALOG:
                next_s.iarg = {8'h00, s.b[uisd_pkg::POS_Q_HI]};
              uisd_pkg::INFO_CONTROL:
              begin
                next_s.iarg = {s.b[uisd_pkg::POS_Q_HI],
                               s.b[uisd_pkg::POS_Q_LO]};
                next_s.st   = uisd_pkg::ST_INFO; // see RULE7
              end
              default:
              begin
                next_s.iv    = 1'b0;
                next_s.fdrop = 1'b1; // see RULE25
              end
            endcase
          end
          uisd_pkg::CMD_GET:
          begin
            next_s.rv   = 1'b1; // see RULE10
            next_s.rid  = frame_id;
            next_s.roff = 16'h0000;
            if (ctl_size > uisd_pkg::SEG_BYTES)
              next_s.st = uisd_pkg::ST_READ; // see RULE11
          end
          uisd_pkg::CMD_PROPS:
          begin
            // Nothing is kept: without a client the frame is dropped.
            if (s.len == uisd_pkg::PROPS_LEN && client_connected)
            begin
              next_s.pv     = 1'b1; // see RULE12 see RULE13
              next_s.pid    = frame_id;
              next_s.pbytes = {s.b[7], s.b[6], s.b[5], s.b[4]};
              next_s.red    = s.b[uisd_pkg::POS_RED]; // see RULE17
              next_s.grn    = s.b[uisd_pkg::POS_GRN];
              next_s.blu    = s.b[uisd_pkg::POS_BLU];
              next_s.scroll = |(s.b[uisd_pkg::POS_PROP]
                                & uisd_pkg::FLAG_SCROLL); // see RULE16
              next_s.capply = |(s.b[uisd_pkg::POS_PROP]
                                & uisd_pkg::FLAG_COLOUR);
              next_s.hide   = |(s.b[uisd_pkg::POS_PROP]
                                & uisd_pkg::FLAG_HIDE); // see RULE14
              next_s.icon   = s.b[uisd_pkg::POS_ICON][3:0];
              next_s.btns   = s.b[uisd_pkg::POS_ICON][7:4];
              next_s.show   = ~|(s.b[uisd_pkg::POS_PROP]
                                 & uisd_pkg::FLAG_HIDE)
                              && ctl_dialog == s.dlg; // see RULE15
            end
            else
              next_s.fdrop = 1'b1;
          end
          uisd_pkg::CMD_SET:
          begin
            if ({s.b[uisd_pkg::POS_OFF_H], s.b[uisd_pkg::POS_OFF_L]}
                == 16'h0000)
              next_s.wdone = 1'b1; // see RULE20
          end
          default: next_s.fdrop = 1'b1; // see RULE25
        endcase
      end
      uisd_pkg::ST_READ:
      begin
        next_s.rv   = 1'b1; // see RULE11
        next_s.roff = next_roff;
        if (17'(next_roff) + 17'(uisd_pkg::SEG_BYTES) >= 17'(ctl_size))
          next_s.st = uisd_pkg::ST_LEN;
      end
      uisd_pkg::ST_INFO:
      begin
        next_s.iv    = 1'b1; // see RULE7
        next_s.ipart = 1'b1;
        next_s.st    = uisd_pkg::ST_LEN;
      end
      default: next_s.st = uisd_pkg::ST_LEN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  // ==========================================================
  // Outputs
  assign rx_ready        = s.st == uisd_pkg::ST_LEN
                           || s.st == uisd_pkg::ST_BODY;
  assign lookup_id       = s.st == uisd_pkg::ST_READ ? s.rid : frame_id;
  assign service_running = s.run;
  assign dialog_index    = s.dlg;
  assign dialog_select   = s.dlg_sel;
  assign client_drop     = s.drop;
  assign data_init       = s.init;
  assign info_valid      = s.iv;
  assign info_sel        = s.isel;
  assign info_arg        = s.iarg;
  assign info_part       = s.ipart;
  assign rd_valid        = s.rv;
  assign rd_id           = s.rid;
  assign rd_offset       = s.roff;
  assign props_valid     = s.pv;
  assign props_id        = s.pid;
  assign props_bytes     = s.pbytes;
  assign colour_red      = s.red;
  assign colour_green    = s.grn;
  assign colour_blue     = s.blu;
  assign scroll_req      = s.scroll;
  assign colour_apply    = s.capply;
  assign msg_hide        = s.hide;
  assign msg_icon        = s.icon;
  assign msg_buttons     = s.btns;
  assign msg_show        = s.show;
  assign wr_valid        = s.wv;
  assign wr_id           = s.wid;
  assign wr_addr         = s.waddr;
  assign wr_data         = s.wdata;
  assign wr_done         = s.wdone;
  assign frame_drop      = s.fdrop;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_start_init;
    s.st == uisd_pkg::ST_EXEC && code == uisd_pkg::CMD_SERVICE
    && s.b[uisd_pkg::POS_ARG] == uisd_pkg::SVC_START
    |=> data_init && service_running;
  endproperty
  a_start_init: assert property (p_start_init) // see RULE4
    else $error("start did not init data");

  property p_drop_keeps;
    client_drop |-> service_running == $past(service_running);
  endproperty
  a_drop_keeps: assert property (p_drop_keeps) // see RULE3
    else $error("disconnect changed service state");

  property p_dialog;
    dialog_select |-> dialog_index == $past(s.b[uisd_pkg::POS_Q_HI]);
  endproperty
  a_dialog: assert property (p_dialog) // see RULE1
    else $error("dialog index not from frame");

  property p_info_two;
    info_valid && !info_part && info_sel == uisd_pkg::INFO_CONTROL
    |=> info_valid && info_part ##1 !info_valid;
  endproperty
  a_info_two: assert property (p_info_two) // see RULE7
    else $error("control query lacks two answers");

  property p_info_one;
    info_valid && info_sel != uisd_pkg::INFO_CONTROL |=> !info_valid;
  endproperty
  a_info_one: assert property (p_info_one) // see RULE7
    else $error("extra info answer");

  property p_read_step;
    rd_valid && $past(rd_valid) |-> rd_offset
      == $past(rd_offset) + uisd_pkg::SEG_BYTES;
  endproperty
  a_read_step: assert property (p_read_step) // see RULE11
    else $error("read segment offset wrong");

  property p_props_conn;
    props_valid |-> $past(client_connected)
      && $past(s.len) == uisd_pkg::PROPS_LEN;
  endproperty
  a_props_conn: assert property (p_props_conn) // see RULE12
    else $error("props sent without client");

  property p_done_zero;
    wr_done |-> $past(s.b[uisd_pkg::POS_OFF_L]) == 8'h00
      && $past(s.b[uisd_pkg::POS_OFF_H]) == 8'h00;
  endproperty
  a_done_zero: assert property (p_done_zero) // see RULE20
    else $error("update done on nonzero offset");

  property p_frame_end;
    s.st == uisd_pkg::ST_BODY && rx_valid && s.cnt == s.len - 8'h01
    |=> !rx_ready ##1 rx_ready || s.st != uisd_pkg::ST_LEN;
  endproperty
  a_frame_end: assert property (p_frame_end) // see RULE24
    else $error("frame end not honoured");

  c_read_multi: cover property (rd_valid ##1 rd_valid);
  c_info_ctrl:  cover property (info_valid && info_part);
  c_wr_done:    cover property (wr_valid ##[1:20] wr_done);
  c_drop:       cover property (frame_drop);

endmodule : uisd_decoder

/* tb/uisd_host_model.sv */
// Host processor model: length-prefixed frames and the interface table.
`timescale 1ns/1ps
module uisd_host_model (
  // Clock
  input  wire logic        clk,
  // Byte stream to the decoder
  output logic             rx_valid,
  output logic [7:0]       rx_byte,
  input  wire logic        rx_ready,
  // Programmed interface table
  input  wire logic [15:0] lookup_id,
  output logic [15:0]      ctl_size,
  output logic [7:0]       ctl_dialog
);
  logic taken;

  initial
  begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end

  always @(posedge clk)
    taken <= rx_valid && rx_ready;

  // One long control, one four-byte list and a message on dialog 1.
  always_comb
  begin
    ctl_size   = 16'h0001;
    ctl_dialog = 8'h00;
    if (lookup_id == 16'h1234)
      ctl_size = 16'h0028;
    if (lookup_id == 16'h0002)
      ctl_size = 16'h0004;
    if (lookup_id == 16'h0B03)
      ctl_dialog = 8'h01;
  end

  // Each byte is held until taken, or for at most 50 cycles; after the last
  // one the line shows the inverse so a stale byte can never pass for fresh data.
  task automatic send_raw(input logic [7:0] f[$]);
    int n;
    foreach (f[i])
    begin
      rx_valid = 1'b1;
      rx_byte  = f[i];
      n = 0;
      do
      begin
        @(posedge clk);
        #1;
        n++;
      end while (!taken && n < 50);
    end
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
  endtask : send_raw

  task automatic send_frame(input logic [7:0] body[$]);
    logic [7:0] f[$];
    f = body;
    f.push_front(8'(body.size() + 1));
    send_raw(f);
  endtask : send_frame
endmodule : uisd_host_model

/* tb/tb.sv */
// Self-checking testbench for the host command decoder.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        reset, rx_valid, rx_ready, client_connected;
  logic [7:0]  rx_byte, ctl_dialog, dialog_index, info_sel, wr_data;
  logic [7:0]  colour_red, colour_green, colour_blue;
  logic [15:0] lookup_id, ctl_size, info_arg, rd_id, rd_offset;
  logic [15:0] props_id, wr_id, wr_addr;
  logic [31:0] props_bytes;
  logic [3:0]  msg_icon, msg_buttons;
  logic        service_running, dialog_select, client_drop, data_init;
  logic        info_valid, info_part, rd_valid, props_valid, scroll_req;
  logic        colour_apply, msg_hide, msg_show, wr_valid, wr_done;
  logic        frame_drop;
  int          n_errors, compares;
  int          n_init, n_sel, n_drop, n_info, n_rd, n_props, n_wr;
  int          n_done, n_fd;
  logic [15:0] rd_q[$];
  logic [23:0] wr_q[$];

  always #50 clk = ~clk;

  uisd_decoder i_uisd_decoder (
    .clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .lookup_id(lookup_id), .ctl_size(ctl_size),
    .ctl_dialog(ctl_dialog), .client_connected(client_connected),
    .service_running(service_running), .dialog_index(dialog_index),
    .dialog_select(dialog_select), .client_drop(client_drop),
    .data_init(data_init), .info_valid(info_valid), .info_sel(info_sel),
    .info_arg(info_arg), .info_part(info_part), .rd_valid(rd_valid),
    .rd_id(rd_id), .rd_offset(rd_offset), .props_valid(props_valid),
    .props_id(props_id), .props_bytes(props_bytes),
    .colour_red(colour_red), .colour_green(colour_green),
    .colour_blue(colour_blue), .scroll_req(scroll_req),
    .colour_apply(colour_apply), .msg_hide(msg_hide),
    .msg_icon(msg_icon), .msg_buttons(msg_buttons), .msg_show(msg_show),
    .wr_valid(wr_valid), .wr_id(wr_id), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_done(wr_done), .frame_drop(frame_drop)
  );

  uisd_host_model i_uisd_host_model (
    .clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .lookup_id(lookup_id), .ctl_size(ctl_size),
    .ctl_dialog(ctl_dialog)
  );

  // ==========================================================
  // Pulse monitors
  always @(posedge clk)
    if (reset === 1'b0)
    begin
      n_init  += int'(data_init === 1'b1);
      n_sel   += int'(dialog_select === 1'b1);
      n_drop  += int'(client_drop === 1'b1);
      n_info  += int'(info_valid === 1'b1);
      n_props += int'(props_valid === 1'b1);
      n_done  += int'(wr_done === 1'b1);
      n_fd    += int'(frame_drop === 1'b1);
      if (rd_valid === 1'b1)
        rd_q.push_back(rd_offset);
      if (wr_valid === 1'b1)
        wr_q.push_back({wr_addr, wr_data});
    end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic clr();
    {n_init, n_sel, n_drop, n_info, n_props, n_done, n_fd} = '0;
    rd_q.delete();
    wr_q.delete();
  endtask : clr

  // Eight cycles cover the two-edge answer plus three read segments.
  task automatic frm(input logic [7:0] b[$]);
    clr();
    i_uisd_host_model.send_frame(b);
    repeat (8) @(posedge clk);
    #1;
  endtask : frm

  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Scenarios
  task automatic t_service();
    frm('{8'h06, 8'h01});
    check(service_running, 1);
    check(n_init, 1);
    frm('{8'h06, 8'h03, 8'h02});
    check(dialog_index, 8'h02);
    frm('{8'h06, 8'h03, 8'h00});
    check(n_sel, 1);
    check(dialog_index, 8'h00);
    frm('{8'h06, 8'h04});
    check(n_drop, 1);
    check(service_running, 1);
    frm('{8'h06, 8'h09});
    check(n_init, 1);
    frm('{8'h06, 8'h02});
    check(service_running, 0);
    $display("service test done");
  endtask : t_service

  task automatic t_info();
    frm('{8'h07, 8'h01});
    check(n_info, 1);
    check(info_sel, 8'h01);
    frm('{8'h07, 8'h02, 8'h05});
    check(n_info, 1);
    check(info_sel, 8'h02);
    check(info_arg, 16'h0005);
    frm('{8'h07, 8'h03, 8'h12, 8'h34});
    check(n_info, 2);
    check(info_part, 1);
    check(info_arg, 16'h1234);
    frm('{8'h07, 8'h04});
    check(n_fd, 1);
    check(n_info, 0);
    $display("info test done");
  endtask : t_info

  task automatic t_read();
    frm('{8'h08, 8'h12, 8'h34});
    check(rd_q.size(), 3);
    for (int i = 0; i < 3; i++)
      check(rd_q[i], 16 * i);
    check(rd_id, 16'h1234);
    frm('{8'h08, 8'h00, 8'h02});
    check(rd_q.size(), 1);
    $display("read test done");
  endtask : t_read

  task automatic t_props();
    client_connected = 1'b1;
    frm('{8'h06, 8'h03, 8'h01});
    frm('{8'h09, 8'h0B, 8'h03, 8'h00, 8'h00, 8'h45, 8'h00,
          8'hFF, 8'h80, 8'h01, 8'h00});
    check(n_props, 1);
    check(props_id, 16'h0B03);
    check(props_bytes, 32'h0045_0000);
    check({msg_buttons, msg_icon, msg_hide}, 9'h08A);
    check(msg_show, 1);
    check({colour_red, colour_green, colour_blue}, 24'hFF8001);
    frm('{8'h09, 8'h0B, 8'h03, 8'h51, 8'h00, 8'h00, 8'h00,
          8'h11, 8'h22, 8'h33, 8'h00});
    check({scroll_req, colour_apply, msg_hide}, 3'b111);
    check(msg_show, 0);
    frm('{8'h06, 8'h03, 8'h00});
    frm('{8'h09, 8'h0B, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h00, 8'h00, 8'h00, 8'h00});
    check(msg_show, 0);
    frm('{8'h09, 8'h0B, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h00, 8'h00, 8'h00});
    check(n_props, 0);
    check(n_fd, 1);
    client_connected = 1'b0;
    frm('{8'h09, 8'h0B, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h00, 8'h00, 8'h00, 8'h00});
    check(n_props, 0);
    check(n_fd, 1);
    $display("properties test done");
  endtask : t_props

  task automatic t_write();
    frm('{8'h0A, 8'h00, 8'h02, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00});
    check(wr_q.size(), 4);
    check(wr_q[0], 24'h000005);
    check(n_done, 1);
    frm('{8'h0A, 8'h07, 8'h05, 8'h10, 8'h00, 8'h51, 8'h52});
    check(wr_q[1], 24'h001152);
    check(wr_id, 16'h0705);
    check(n_done, 0);
    frm('{8'h0A, 8'h07, 8'h05, 8'h00, 8'h00, 8'h41});
    check(n_done, 1);
    $display("write test done");
  endtask : t_write

  task automatic t_drop();
    clr();
    i_uisd_host_model.send_raw('{8'h03, 8'h0B, 8'h00, 8'h01,
                                 8'h04, 8'h08, 8'h00, 8'h02});
    repeat (8) @(posedge clk);
    #1;
    check(n_fd, 2);
    check(rd_q.size(), 1);
    $display("discard test done");
  endtask : t_drop

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    reset = 1'b1;
    client_connected = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    t_service();
    t_info();
    t_read();
    t_props();
    t_write();
    t_drop();
    give_verdict();
  end

  initial
  begin
    #1000000;
    n_errors++;
    $display("BAD at %0t: run took too long", $time);
    give_verdict();
  end
endmodule : tb
